// ===== tb/rtc_pit_asserts.sv
// Port-level checker for the real-time counter block.
// Assumes the reference pins toggle slower than core_clk_i / 8.
`timescale 1ns/1ps
`default_nettype none
module rtc_pit_asserts (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Register bus
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Interrupt and events
  input wire logic irq_o,
  input wire logic ovf_evt_o,
  input wire logic cmp_evt_o,
  input wire logic [7:0] pit_evt_o,
  input wire logic periodic_tick_timer_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  property p_answer;
    s_req |=> s_ack;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not one cycle");
  property p_ack_cause;
    !avs_waitrequest_o |-> $past(avs_read_i) || $past(avs_write_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  property p_unmapped;
    (avs_read_i && avs_address_i == 6'h3c && !avs_waitrequest_o) |-> avs_readdata_o == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reset_idle;
    $rose(nrst_i) |-> (avs_waitrequest_o && !irq_o && pit_evt_o == 8'h00) [*2];
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  property p_ovf_len;
    $rose(ovf_evt_o) |-> ovf_evt_o [*5];
  endproperty
  a_ovf_len: assert property (p_ovf_len) else $error("overflow event too short");
  property p_cmp_len;
    $rose(cmp_evt_o) |-> cmp_evt_o [*5];
  endproperty
  a_cmp_len: assert property (p_cmp_len) else $error("compare event too short");
  property p_div_evt_ripple;
    ($changed(pit_evt_o[1]) && pit_evt_o != 8'h00) |-> $fell(pit_evt_o[0]);
  endproperty
  a_div_evt_ripple: assert property (p_div_evt_ripple) else $error("divider event skew");
  property p_tick_hold;
    $changed(periodic_tick_timer_o) |=> $stable(periodic_tick_timer_o) [*8];
  endproperty
  a_tick_hold: assert property (p_tick_hold) else $error("tick output too fast");
endmodule
bind rtc_pit rtc_pit_asserts u_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
  .ovf_evt_o(ovf_evt_o), .cmp_evt_o(cmp_evt_o), .pit_evt_o(pit_evt_o),
  .periodic_tick_timer_o(periodic_tick_timer_o));
`default_nettype wire

// ===== tb/rtc_pit_tb_top.sv
// Self-checking bench for the real-time counter block.
// One divided clock feeds all three reference pins; no far-side model.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_pit_regs.vh"
module rtc_pit_tb_top;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ref_q = 1'b0;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'hf;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, irq_o, ovf_evt_o, cmp_evt_o, periodic_tick_timer_o;
  wire [7:0] pit_evt_o;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int div_q = 0;
  int n;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] mon_e, mon_m, per, cmpv;
  logic [5:0] rst_a[5] = '{`OFS_CTRL, `OFS_PER, `OFS_CMP, `OFS_INT_STATUS, 6'h3c};
  logic [31:0] rst_v[5] = '{32'h0, {16'h0000, `PER_RESET}, 32'h0, 32'h0, 32'h0};

  rtc_pit uut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .crystal_input_pin_i(ref_q),
    .ext_clk_i(ref_q), .low_power_internal_osc_i(ref_q), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .ovf_evt_o(ovf_evt_o),
    .cmp_evt_o(cmp_evt_o), .pit_evt_o(pit_evt_o),
    .periodic_tick_timer_o(periodic_tick_timer_o));

  always #5 core_clk_i = ~core_clk_i;

  task automatic test_done();
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Reads note the expectation; the monitor below compares on the answer edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    if (!w) begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge core_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wait_irq(input int lim, output int k);
    k = 0;
    // Let a clearing read settle before irq_o is looked at
    @(posedge core_clk_i);
    while (irq_o !== 1'b1 && k < lim) begin
      @(posedge core_clk_i);
      k++;
    end
    chk("irq_o", 32'h1, {31'h0, irq_o});
  endtask

  // Reference period of 10 cycles keeps it under core_clk_i / 8
  always @(posedge core_clk_i) begin
    div_q <= (div_q == 4) ? 0 : div_q + 1;
    if (div_q == 4) begin
      ref_q <= ~ref_q;
    end
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors = errors + 1;
      test_done();
    end
  end

  always @(posedge core_clk_i) begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
      mon_e = exp_q.pop_front();
      mon_m = msk_q.pop_front();
      chk("readdata", mon_e & mon_m, avs_readdata_o & mon_m);
    end
  end

  initial begin
    void'($urandom(32'ha5d7_56c7));
    repeat (12) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk("pit_evt_o", 32'h0, {24'h0, pit_evt_o});
    bus(1'b1, 6'h3c, 32'hffff_ffff, 32'h0);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, rst_a[i], rst_v[i], 32'hffff_ffff);
    end
    per = 32'h3 + ($urandom % 6);
    cmpv = $urandom % per;
    bus(1'b1, `OFS_PER, per, 32'h0);
    bus(1'b1, `OFS_CMP, cmpv, 32'h0);
    bus(1'b1, `OFS_EVT_CTRL, 32'h0000_0003, 32'h0);
    bus(1'b1, `OFS_INT_MASK, 32'h0000_0001, 32'h0);
    bus(1'b1, `OFS_CTRL, 32'h0000_0001, 32'h0);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, `OFS_CLKSEL, s, 32'h0);
      bus(1'b0, `OFS_INT_STATUS, 32'h0, 32'h0);
      wait_irq(4000, n);
      bus(1'b0, `OFS_INT_STATUS, 32'h0000_0001, 32'h0000_0001);
      bus(1'b0, `OFS_INT_STATUS, 32'h0, 32'h0000_0001);
    end
    bus(1'b1, `OFS_INT_MASK, 32'h0000_0002, 32'h0);
    bus(1'b1, `OFS_CLKSEL, 32'h0, 32'h0);
    bus(1'b0, `OFS_INT_STATUS, 32'h0, 32'h0);
    wait_irq(500, n);
    bus(1'b0, `OFS_INT_STATUS, 32'h0000_0002, 32'h0000_0002);
    bus(1'b1, `OFS_INT_MASK, 32'h0, 32'h0);
    repeat (200) @(posedge core_clk_i);
    chk("irq_o", 32'h0, {31'h0, irq_o});
    bus(1'b0, `OFS_INT_STATUS, 32'h0000_0003, 32'h0000_0003);
    // Divide by 4: overflow needs per+1 ticks of 40 cycles after CNT is zeroed
    bus(1'b1, `OFS_INT_MASK, 32'h0000_0001, 32'h0);
    bus(1'b1, `OFS_CTRL, 32'h0000_0005, 32'h0);
    bus(1'b1, `OFS_CNT, 32'h0, 32'h0);
    bus(1'b0, `OFS_INT_STATUS, 32'h0, 32'h0);
    wait_irq(2000, n);
    chk("ovf_time", 32'h1, {31'h0, n >= per * 40 - 5 && n <= per * 40 + 50});
    bus(1'b1, `OFS_CTRL, 32'h0, 32'h0);
    bus(1'b1, `OFS_CNT, 32'h0000_0005, 32'h0);
    repeat (300) @(posedge core_clk_i);
    bus(1'b0, `OFS_CNT, 32'h0000_0005, 32'h0000_ffff);
    bus(1'b0, `OFS_STATE, 32'h0, 32'h0001_7fff);
    bus(1'b1, `OFS_INT_MASK, 32'h0000_0004, 32'h0);
    bus(1'b1, `OFS_PIT_CTRL, 32'h0000_0003, 32'h0);
    bus(1'b0, `OFS_INT_STATUS, 32'h0, 32'h0);
    wait_irq(200, n);
    bus(1'b0, `OFS_INT_STATUS, 32'h0000_0004, 32'h0000_0004);
    wait_irq(200, n);
    chk("tick_period", 32'h1, {31'h0, n >= 30 && n <= 42});
    bus(1'b0, `OFS_CNT, 32'h0000_0005, 32'h0000_ffff);
    repeat (2700) @(posedge core_clk_i);
    // Switch off away from a tick edge so the output hold time is honoured
    @(posedge periodic_tick_timer_o);
    // No event bit can move in the few cycles after a tick rise
    @(negedge core_clk_i);
    bus(1'b0, `OFS_STATE, {19'h0_0000, pit_evt_o, 5'h00}, 32'h0000_1fe0);
    repeat (8) @(posedge core_clk_i);
    bus(1'b1, `OFS_PIT_CTRL, 32'h0, 32'h0);
    repeat (20) @(posedge core_clk_i);
    chk("pit_evt_o", 32'h0, {24'h0, pit_evt_o});
    // A cleared correction enable must leave the running window alive
    bus(1'b1, `OFS_CALIB, 32'h0000_0001, 32'h0);
    bus(1'b1, `OFS_CTRL, 32'h0000_0080, 32'h0);
    bus(1'b1, `OFS_CTRL, 32'h0000_0000, 32'h0);
    bus(1'b0, `OFS_STATE, 32'h0001_0000, 32'h0001_0000);
    test_done();
  end
endmodule
`default_nettype wire

// ===== verilog/rtc_pit.v
// Real-time counter with a shared 15-bit prescaler, periodic tick timer
// and crystal error correction, behind an Avalon-MM slave.
// Assumes the reference clock pins are far slower than core_clk_i.
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_pit_regs.vh"

module rtc_pit (
  // Clock and reset
  input wire core_clk_i,
  input wire nrst_i,
  // Reference clock pins
  input wire crystal_input_pin_i,
  input wire ext_clk_i,
  input wire low_power_internal_osc_i,
  // Avalon-MM slave
  input wire [5:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // Interrupt and events
  output wire irq_o,
  output wire ovf_evt_o,
  output wire cmp_evt_o,
  output wire [7:0] pit_evt_o,
  output wire periodic_tick_timer_o
);

  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        be_merge[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
      end
    end
  endfunction

  // True when the prescaler moved across a 2^sel boundary
  function div_tick;
    input [15:0] old_v;
    input [15:0] new_v;
    input [3:0] sel;
    begin
      div_tick = ((new_v >> sel) != (old_v >> sel));
    end
  endfunction

  // Reset release
  reg rst_s1_q;
  reg rst_n_q;
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Pin synchronisers: stage 1 feeds only stage 2
  reg [2:0] pin_s1_q;
  reg [2:0] pin_s2_q;
  reg [2:0] pin_s3_q;
  reg [4:0] osc_div_q;
  wire [2:0] pin_rise = pin_s2_q & ~pin_s3_q;
  always @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_s3_q <= 3'h0;
      osc_div_q <= 5'h00;
    end else begin
      pin_s1_q <= {low_power_internal_osc_i, ext_clk_i, crystal_input_pin_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_rise[2]) begin
        osc_div_q <= osc_div_q + 5'h01;
      end
    end
  end

  // Registers
  reg [7:0] ctrl_q;
  reg [1:0] clksel_q;
  reg [15:0] cnt_q;
  reg [15:0] per_q;
  reg [15:0] cmp_q;
  reg [2:0] flags_q;
  reg [2:0] mask_q;
  reg [4:0] pit_ctrl_q;
  reg [7:0] calib_q;
  reg [1:0] evt_ctrl_q;
  reg [14:0] presc_q;
  reg [19:0] win_q;
  reg [19:0] acc_q;
  reg corr_run_q;
  reg pit_q;
  reg ovf_evt_q;
  reg cmp_evt_q;
  reg [7:0] pit_evt_q;
  reg irq_q;
  reg wait_q;
  reg [31:0] rdata_q;

  wire cnt_en = ctrl_q[`CTRL_CNT_EN];
  wire [3:0] presc_sel = ctrl_q[`CTRL_PRESC_MSB:`CTRL_PRESC_LSB];
  wire corr_en = ctrl_q[`CTRL_CORR_EN];
  wire pit_en = pit_ctrl_q[`PIT_EN];
  wire [3:0] pit_per = pit_ctrl_q[`PIT_PER_MSB:`PIT_PER_LSB];
  wire [6:0] err_mag = calib_q[`CALIB_ERR_MSB:0];
  wire err_slow = calib_q[`CALIB_SIGN];

  // Reference selection
  reg ref_tick;
  always @* begin
    case (clksel_q)
      `CLK_XTAL: ref_tick = pin_rise[0];
      `CLK_EXT: ref_tick = pin_rise[1];
      `CLK_OSC: ref_tick = pin_rise[2];
      default: ref_tick = pin_rise[2] && (osc_div_q == `OSC_DIV_LAST);
    endcase
  end

  // Correction: spread err_mag actions over a million reference cycles
  wire presc_on = cnt_en | pit_en;
  wire [20:0] acc_sum = {1'b0, acc_q} + {14'h0000, err_mag};
  wire corr_hit = corr_run_q && ref_tick && (acc_sum >= {1'b0, `CORR_WINDOW});
  wire win_end = (win_q == `CORR_WINDOW - 20'h0_0001);

  // Prescaler step: +2 skips a count, +0 inserts an extra one
  reg [15:0] presc_inc;
  always @* begin
    if (!presc_on || !ref_tick) begin
      presc_inc = 16'h0000;
    end else if (corr_hit) begin
      presc_inc = err_slow ? 16'h0000 : 16'h0002;
    end else begin
      presc_inc = 16'h0001;
    end
  end
  wire [15:0] presc_old = {1'b0, presc_q};
  wire [15:0] presc_new = presc_old + presc_inc;
  wire cnt_tick = cnt_en && div_tick(presc_old, presc_new, presc_sel);

  // Periodic bit: bit p toggles every 2^p, full period 2^(p+1)
  wire pit_valid = pit_en && (pit_per != 4'h0) && (pit_per != 4'hF);
  wire pit_bit = pit_valid && presc_new[pit_per];
  wire pit_fire = pit_bit && !pit_q;

  wire cmp_hit = cnt_tick && (cnt_q == cmp_q);
  wire ovf_hit = cnt_tick && (cnt_q == per_q);

  // Bus access takes effect at the edge where waitrequest is low
  wire bus_req = avs_read_i | avs_write_i;
  wire acc_done = bus_req && !wait_q;
  wire wr_done = acc_done && avs_write_i;
  wire rd_clear = acc_done && avs_read_i && (avs_address_i == `OFS_INT_STATUS);
  wire wr_ctrl = wr_done && (avs_address_i == `OFS_CTRL);
  wire wr_cnt = wr_done && (avs_address_i == `OFS_CNT);
  wire [31:0] wmerge_ctrl = be_merge({24'h00_0000, ctrl_q}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] wmerge_per = be_merge({16'h0000, per_q}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] wmerge_cmp = be_merge({16'h0000, cmp_q}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] wmerge_cnt = be_merge({16'h0000, cnt_q}, avs_writedata_i, avs_byteenable_i);
  wire [2:0] flag_set = {pit_fire, cmp_hit, ovf_hit};
  // Clear only what the read returned, so an event landing after capture is kept
  wire [2:0] flags_nxt = (flags_q & ~({3{rd_clear}} & rdata_q[2:0])) | flag_set;

  // Read mux
  reg [31:0] rd_mux;
  always @* begin
    case (avs_address_i)
      `OFS_CTRL: rd_mux = {24'h00_0000, ctrl_q};
      `OFS_CLKSEL: rd_mux = {30'h0000_0000, clksel_q};
      `OFS_CNT: rd_mux = {16'h0000, cnt_q};
      `OFS_PER: rd_mux = {16'h0000, per_q};
      `OFS_CMP: rd_mux = {16'h0000, cmp_q};
      `OFS_INT_STATUS: rd_mux = {29'h0000_0000, flags_q};
      `OFS_INT_MASK: rd_mux = {29'h0000_0000, mask_q};
      `OFS_PIT_CTRL: rd_mux = {27'h000_0000, pit_ctrl_q};
      `OFS_CALIB: rd_mux = {24'h00_0000, calib_q};
      `OFS_EVT_CTRL: rd_mux = {30'h0000_0000, evt_ctrl_q};
      `OFS_STATE: rd_mux = {15'h0000, corr_run_q, 1'b0, presc_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus handshake: one wait cycle, then answer
  always @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= !(bus_req && wait_q);
      if (bus_req && wait_q && avs_read_i) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Software registers
  always @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= 8'h00;
      clksel_q <= `CLK_XTAL;
      per_q <= `PER_RESET;
      cmp_q <= `CMP_RESET;
      mask_q <= 3'h0;
      pit_ctrl_q <= 5'h00;
      calib_q <= 8'h00;
      evt_ctrl_q <= 2'h0;
    end else if (wr_done) begin
      case (avs_address_i)
        `OFS_CTRL: ctrl_q <= wmerge_ctrl[7:0];
        `OFS_CLKSEL: begin
          if (avs_byteenable_i[0]) begin
            clksel_q <= avs_writedata_i[1:0];
          end
        end
        `OFS_PER: per_q <= wmerge_per[15:0];
        `OFS_CMP: cmp_q <= wmerge_cmp[15:0];
        `OFS_INT_MASK: begin
          if (avs_byteenable_i[0]) begin
            mask_q <= avs_writedata_i[2:0];
          end
        end
        `OFS_PIT_CTRL: begin
          if (avs_byteenable_i[0]) begin
            pit_ctrl_q <= avs_writedata_i[4:0];
          end
        end
        `OFS_CALIB: begin
          if (avs_byteenable_i[0]) begin
            calib_q <= avs_writedata_i[7:0];
          end
        end
        `OFS_EVT_CTRL: begin
          if (avs_byteenable_i[0]) begin
            evt_ctrl_q <= avs_writedata_i[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Prescaler and correction window
  always @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      presc_q <= 15'h0000;
      win_q <= 20'h0_0000;
      acc_q <= 20'h0_0000;
      corr_run_q <= 1'b0;
    end else begin
      if (!presc_on) begin
        presc_q <= 15'h0000;
      end else begin
        presc_q <= presc_new[14:0];
      end
      if (!corr_run_q) begin
        corr_run_q <= corr_en;
        win_q <= 20'h0_0000;
        acc_q <= 20'h0_0000;
      end else if (ref_tick) begin
        if (win_end) begin
          // A cleared enable only takes hold here, once the window is done
          corr_run_q <= corr_en;
          win_q <= 20'h0_0000;
          acc_q <= 20'h0_0000;
        end else begin
          win_q <= win_q + 20'h0_0001;
          acc_q <= corr_hit ? (acc_sum[19:0] - `CORR_WINDOW) : acc_sum[19:0];
        end
      end
    end
  end

  // Counter
  always @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cnt_q <= 16'h0000;
    end else if (wr_cnt) begin
      cnt_q <= wmerge_cnt[15:0];
    end else if (ovf_hit) begin
      cnt_q <= 16'h0000;
    end else if (cnt_tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Flags, interrupt and events
  always @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flags_q <= 3'h0;
      irq_q <= 1'b0;
      pit_q <= 1'b0;
      ovf_evt_q <= 1'b0;
      cmp_evt_q <= 1'b0;
      pit_evt_q <= 8'h00;
    end else begin
      // A new event in the clearing cycle survives the read
      flags_q <= flags_nxt;
      irq_q <= |(flags_nxt & mask_q);
      pit_q <= pit_bit;
      // Event pulses last one reference period
      if (ovf_hit || ref_tick) begin
        ovf_evt_q <= ovf_hit && evt_ctrl_q[`EVT_OVF];
      end
      if (cmp_hit || ref_tick) begin
        cmp_evt_q <= cmp_hit && evt_ctrl_q[`EVT_CMP];
      end
      pit_evt_q <= pit_en ? presc_new[`PIT_EVT_LSB +: 8] : 8'h00;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign irq_o = irq_q;
  assign ovf_evt_o = ovf_evt_q;
  assign cmp_evt_o = cmp_evt_q;
  assign pit_evt_o = pit_evt_q;
  assign periodic_tick_timer_o = pit_q;

endmodule
`default_nettype wire

// ===== verilog/rtc_pit_regs.vh
// Register map, field positions, reset values and counts of the
// real-time counter with periodic tick timer.
// Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef RTC_PIT_REGS_VH
`define RTC_PIT_REGS_VH

// Byte offsets
`define OFS_CTRL 6'h00
`define OFS_CLKSEL 6'h04
`define OFS_CNT 6'h08
`define OFS_PER 6'h0C
`define OFS_CMP 6'h10
`define OFS_INT_STATUS 6'h14
`define OFS_INT_MASK 6'h18
`define OFS_PIT_CTRL 6'h1C
`define OFS_CALIB 6'h20
`define OFS_EVT_CTRL 6'h24
`define OFS_STATE 6'h28

// CTRL fields
`define CTRL_CNT_EN 0
`define CTRL_PRESC_LSB 1
`define CTRL_PRESC_MSB 4
`define CTRL_CORR_EN 7

// PIT_CTRL fields
`define PIT_EN 0
`define PIT_PER_LSB 1
`define PIT_PER_MSB 4

// CALIB fields: magnitude in ppm, sign 1 = slow down
`define CALIB_ERR_MSB 6
`define CALIB_SIGN 7

// Interrupt status / mask bits
`define INT_OVF 0
`define INT_CMP 1
`define INT_PIT 2

// Event enable bits
`define EVT_OVF 0
`define EVT_CMP 1

// Clock select codes
`define CLK_XTAL 2'h0
`define CLK_EXT 2'h1
`define CLK_OSC 2'h2
`define CLK_OSC_DIV32 2'h3

// Reset values
`define PER_RESET 16'hFFFF
`define CMP_RESET 16'h0000

// Correction window: one million reference cycles
`define CORR_WINDOW 20'hF_4240
`define OSC_DIV_LAST 5'h1F

// Lowest PIT event output bit of the prescaler (divide by 64)
`define PIT_EVT_LSB 5

`endif
